// *** hdl/line_monitor_pkg.sv ***
// Package for the line monitor readback block: register map, fields, scale steps.
// Assumes an 8-bit register port and converter samples in uW/mV/uA units.
package line_monitor_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int SEL_W = 3;
	localparam int NUM_XSTR = 6;
	localparam int CODE_W = 8;
	localparam int MAG_W = 6;
	localparam int CALC_W = 24;

	// Register offsets
	localparam logic [ADDR_W-1:0] ADDR_PWR_SEL = 8'h4C;
	localparam logic [ADDR_W-1:0] ADDR_PWR = 8'h4D;
	localparam logic [ADDR_W-1:0] ADDR_LOOP_V = 8'h4E;
	localparam logic [ADDR_W-1:0] ADDR_LOOP_I = 8'h4F;
	localparam logic [ADDR_W-1:0] ADDR_TIP = 8'h50;
	localparam logic [ADDR_W-1:0] ADDR_RING = 8'h51;

	// Field layout of the signed loop registers
	localparam int SIGN_BIT = 6;
	localparam int MAG_MSB = 5;

	// Transistor select codes
	localparam logic [SEL_W-1:0] SEL_Q3 = 3'h2;
	localparam logic [SEL_W-1:0] SEL_Q4 = 3'h3;
	localparam logic [SEL_W-1:0] SEL_LAST = 3'h5;

	// Reset values, read idle value and top codes
	localparam logic [CODE_W-1:0] RST_CODE = 8'h00;
	localparam logic [SEL_W-1:0] RST_SEL = 3'h0;
	localparam logic [DATA_W-1:0] RD_IDLE = 8'h00;
	localparam logic [CODE_W-1:0] CODE_MAX = 8'hFF;
	localparam logic [MAG_W-1:0] MAG_MAX = 6'h3F;

	// One code step of each quantity, in the unit of its input sample
	localparam logic [CALC_W-1:0] PWR_BIG_STEP_UW = 24'h0076C0;
	localparam logic [CALC_W-1:0] PWR_SMALL_STEP_UW = 24'h000E24;
	localparam logic [CALC_W-1:0] GND_V_STEP_MV = 24'h000178;
	localparam logic [CALC_W-1:0] LOOP_V_STEP_MV = 24'h0005DC;
	localparam logic [CALC_W-1:0] LOOP_I_STEP_UA = 24'h0004E2;
endpackage : line_monitor_pkg

// *** hdl/line_monitor_readback.sv ***
// Read-only line measurement registers plus the transistor power select pointer.
// Assumes converter samples arrive with a one-cycle meas_valid, synchronous to core_clk.
`timescale 1ns/100ps
module line_monitor_readback
	import line_monitor_pkg::*;
#(
	parameter int PWR_W = 24,
	parameter int VOLT_W = 18,
	parameter int CUR_W = 18
)
(
	input wire logic core_clk, // 100 MHz clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic [ADDR_W-1:0] reg_addr, // Register address
	input wire logic [DATA_W-1:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [DATA_W-1:0] reg_rdata, // Read data, cycle after reg_rd
	input wire logic meas_valid, // New converter sample set
	input wire logic [NUM_XSTR-1:0][PWR_W-1:0] xstr_power_uw, // Per-transistor power, uW
	input wire logic signed [VOLT_W-1:0] tip_mv, // Tip to ground, mV
	input wire logic signed [VOLT_W-1:0] ring_mv, // Ring to ground, mV
	input wire logic signed [CUR_W-1:0] loop_ua, // Loop current, uA, forward positive
	output logic [SEL_W-1:0] power_monitor_select // Current transistor pointer
);

	generate
		if (PWR_W > CALC_W || VOLT_W + 1 > CALC_W || CUR_W + 1 > CALC_W || VOLT_W < 2 || CUR_W < 2)
		begin : g_bad_width
			$error("line_monitor_readback: sample widths exceed the scaling datapath");
		end
	endgenerate

	// Magnitude divided by one step, pinned at the top code
	function automatic logic [CODE_W-1:0] scale_code(input logic [CALC_W-1:0] mag,
		input logic [CALC_W-1:0] step, input logic [CODE_W-1:0] top);
		logic [CALC_W-1:0] q;
		q = mag / step;
		if (q > {{(CALC_W-CODE_W){1'b0}}, top})
			return top;
		return q[CODE_W-1:0];
	endfunction : scale_code

	function automatic logic [CALC_W-1:0] abs_calc(input logic signed [CALC_W-1:0] v);
		logic signed [CALC_W-1:0] n;
		n = -v;
		return v[CALC_W-1] ? n : v;
	endfunction : abs_calc

	logic [SEL_W-1:0] sel_r;
	logic [SEL_W-1:0] sel_nxt;
	logic [NUM_XSTR-1:0][CODE_W-1:0] xstr_code_r;
	logic [NUM_XSTR-1:0][CODE_W-1:0] xstr_code_nxt;
	logic [CODE_W-1:0] loop_v_r;
	logic [CODE_W-1:0] loop_v_nxt;
	logic [CODE_W-1:0] loop_i_r;
	logic [CODE_W-1:0] loop_i_nxt;
	logic [CODE_W-1:0] tip_r;
	logic [CODE_W-1:0] tip_nxt;
	logic [CODE_W-1:0] ring_r;
	logic [CODE_W-1:0] ring_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;

	// Per-transistor power codes; Q3 and Q4 share the small step, the others the big step
	genvar gi;
	generate
		for (gi = 0; gi < NUM_XSTR; gi++)
		begin : g_xstr
			localparam logic [SEL_W-1:0] CH = SEL_W'(gi);
			wire small_xstr = (CH == SEL_Q3) || (CH == SEL_Q4);
			wire [CALC_W-1:0] step = small_xstr ? PWR_SMALL_STEP_UW : PWR_BIG_STEP_UW;
			wire [CALC_W-1:0] pwr_ext = CALC_W'(xstr_power_uw[gi]);
			assign xstr_code_nxt[gi] = meas_valid ? scale_code(pwr_ext, step, CODE_MAX) : xstr_code_r[gi];
		end
	endgenerate

	// Loop and ground-referenced quantities
	wire signed [CALC_W-1:0] tip_ext = CALC_W'(tip_mv);
	wire signed [CALC_W-1:0] ring_ext = CALC_W'(ring_mv);
	wire signed [CALC_W-1:0] cur_ext = CALC_W'(loop_ua);
	wire signed [CALC_W-1:0] loop_diff = tip_ext - ring_ext;
	// Tip and ring only go negative; a positive excursion reads as zero
	wire [CALC_W-1:0] tip_mag = tip_ext[CALC_W-1] ? abs_calc(tip_ext) : '0;
	wire [CALC_W-1:0] ring_mag = ring_ext[CALC_W-1] ? abs_calc(ring_ext) : '0;
	wire [CODE_W-1:0] loop_v_mag = scale_code(abs_calc(loop_diff), LOOP_V_STEP_MV, CODE_W'(MAG_MAX));
	wire [CODE_W-1:0] loop_i_mag = scale_code(abs_calc(cur_ext), LOOP_I_STEP_UA, CODE_W'(MAG_MAX));
	wire [CODE_W-1:0] loop_v_code = {1'b0, loop_diff[CALC_W-1], loop_v_mag[MAG_MSB:0]};
	wire [CODE_W-1:0] loop_i_code = {1'b0, cur_ext[CALC_W-1], loop_i_mag[MAG_MSB:0]};

	assign loop_v_nxt = meas_valid ? loop_v_code : loop_v_r;
	assign loop_i_nxt = meas_valid ? loop_i_code : loop_i_r;
	assign tip_nxt = meas_valid ? scale_code(tip_mag, GND_V_STEP_MV, CODE_MAX) : tip_r;
	assign ring_nxt = meas_valid ? scale_code(ring_mag, GND_V_STEP_MV, CODE_MAX) : ring_r;

	// Pointer follows the selected code immediately, no resampling needed
	wire sel_defined = (sel_r <= SEL_LAST);
	wire [CODE_W-1:0] power_code = sel_defined ? xstr_code_r[sel_r] : RST_CODE;

	// Register decode; only the pointer accepts writes
	wire wr_sel = reg_wr && (reg_addr == ADDR_PWR_SEL);
	assign sel_nxt = wr_sel ? reg_wdata[SEL_W-1:0] : sel_r;

	wire hit_sel = (reg_addr == ADDR_PWR_SEL);
	wire hit_pwr = (reg_addr == ADDR_PWR);
	wire hit_lv = (reg_addr == ADDR_LOOP_V);
	wire hit_li = (reg_addr == ADDR_LOOP_I);
	wire hit_tip = (reg_addr == ADDR_TIP);
	wire hit_ring = (reg_addr == ADDR_RING);
	wire [DATA_W-1:0] rd_mux =
		hit_sel ? DATA_W'(sel_r) :
		hit_pwr ? power_code :
		hit_lv ? loop_v_r :
		hit_li ? loop_i_r :
		hit_tip ? tip_r :
		hit_ring ? ring_r : RD_IDLE;
	// Data stands only in the cycle after the strobe, idle zero otherwise
	assign rdata_nxt = reg_rd ? rd_mux : RD_IDLE;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			sel_r <= RST_SEL;
			rdata_r <= RD_IDLE;
		end
		else
		begin
			sel_r <= sel_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			xstr_code_r <= '0;
			loop_v_r <= RST_CODE;
			loop_i_r <= RST_CODE;
			tip_r <= RST_CODE;
			ring_r <= RST_CODE;
		end
		else
		begin
			xstr_code_r <= xstr_code_nxt;
			loop_v_r <= loop_v_nxt;
			loop_i_r <= loop_i_nxt;
			tip_r <= tip_nxt;
			ring_r <= ring_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign power_monitor_select = sel_r;

	// Checks
	localparam logic [CALC_W-1:0] PWR_BIG_STEP = PWR_BIG_STEP_UW;
	localparam logic [CALC_W-1:0] PWR_SMALL_STEP = PWR_SMALL_STEP_UW;
	// Magnitudes as the scaling sees them, for the step checks below
	wire [CALC_W-1:0] loop_v_abs = abs_calc(loop_diff);
	wire [CALC_W-1:0] loop_i_abs = abs_calc(cur_ext);

	property p_power_select;
		@(posedge core_clk) disable iff (sys_rst)
		reg_rd && hit_pwr && sel_defined |=> reg_rdata == $past(xstr_code_r[sel_r]);
	endproperty
	a_power_select: assert property (p_power_select) else $error("power read not from selected transistor");

	property p_power_big;
		@(posedge core_clk) disable iff (sys_rst)
		meas_valid && CALC_W'(xstr_power_uw[0]) < PWR_BIG_STEP * 255 |=>
			CALC_W'(xstr_code_r[0]) * PWR_BIG_STEP <= CALC_W'($past(xstr_power_uw[0]))
			&& CALC_W'($past(xstr_power_uw[0])) < (CALC_W'(xstr_code_r[0]) + 1) * PWR_BIG_STEP;
	endproperty
	a_power_big: assert property (p_power_big) else $error("Q1 power code off its 30.4 mW scale");

	property p_power_small;
		@(posedge core_clk) disable iff (sys_rst)
		meas_valid && CALC_W'(xstr_power_uw[2]) < PWR_SMALL_STEP * 255 |=>
			CALC_W'(xstr_code_r[2]) * PWR_SMALL_STEP <= CALC_W'($past(xstr_power_uw[2]))
			&& CALC_W'($past(xstr_power_uw[2])) < (CALC_W'(xstr_code_r[2]) + 1) * PWR_SMALL_STEP;
	endproperty
	a_power_small: assert property (p_power_small) else $error("Q3 power code off its 3.62 mW scale");

	property p_loop_v_sign;
		@(posedge core_clk) disable iff (sys_rst)
		meas_valid |=> loop_v_r[7] == 1'b0 && loop_v_r[SIGN_BIT] == ($past(tip_mv) < $past(ring_mv));
	endproperty
	a_loop_v_sign: assert property (p_loop_v_sign) else $error("loop voltage polarity wrong");

	property p_loop_v_mag;
		@(posedge core_clk) disable iff (sys_rst)
		meas_valid && abs_calc(loop_diff) >= LOOP_V_STEP_MV * 64 |=> loop_v_r[MAG_MSB:0] == MAG_MAX;
	endproperty
	a_loop_v_mag: assert property (p_loop_v_mag) else $error("loop voltage not pinned at full scale");

	property p_loop_i_sign;
		@(posedge core_clk) disable iff (sys_rst)
		meas_valid |=> loop_i_r[7] == 1'b0 && loop_i_r[SIGN_BIT] == ($past(loop_ua) < 0);
	endproperty
	a_loop_i_sign: assert property (p_loop_i_sign) else $error("loop current polarity wrong");

	property p_loop_i_mag;
		@(posedge core_clk) disable iff (sys_rst)
		meas_valid && abs_calc(cur_ext) < LOOP_I_STEP_UA |=> loop_i_r[MAG_MSB:0] == '0;
	endproperty
	a_loop_i_mag: assert property (p_loop_i_mag) else $error("loop current below one step not zero");

	property p_tip_scale;
		@(posedge core_clk) disable iff (sys_rst)
		meas_valid && tip_mag < GND_V_STEP_MV * 255 |=>
			CALC_W'(tip_r) * GND_V_STEP_MV <= $past(tip_mag) && $past(tip_mag) < (CALC_W'(tip_r) + 1) * GND_V_STEP_MV;
	endproperty
	a_tip_scale: assert property (p_tip_scale) else $error("tip code off its 0.376 V scale");

	property p_ring_hold;
		@(posedge core_clk) disable iff (sys_rst)
		!meas_valid ##1 !meas_valid |-> $stable(ring_r) && $stable(tip_r);
	endproperty
	a_ring_hold: assert property (p_ring_hold) else $error("ground voltage code moved with no sample");

	property p_sel_undefined;
		@(posedge core_clk) disable iff (sys_rst)
		reg_rd && hit_pwr && !sel_defined |=> reg_rdata == RD_IDLE;
	endproperty
	a_sel_undefined: assert property (p_sel_undefined) else $error("undefined pointer code gave power data");

	property p_ro_write;
		@(posedge core_clk) disable iff (sys_rst)
		reg_wr && !meas_valid && (hit_lv || hit_li || hit_tip || hit_ring || hit_pwr) |=>
			$stable(loop_v_r) && $stable(loop_i_r) && $stable(tip_r) && $stable(ring_r) && $stable(sel_r);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("write changed a measurement register");

	// Exact mid-range steps; the pinned ends have their own checks
	property p_loop_v_scale;
		@(posedge core_clk) disable iff (sys_rst)
		meas_valid && loop_v_abs < LOOP_V_STEP_MV * 63 |=>
			CALC_W'(loop_v_r[MAG_MSB:0]) * LOOP_V_STEP_MV <= $past(loop_v_abs)
			&& $past(loop_v_abs) < (CALC_W'(loop_v_r[MAG_MSB:0]) + 1) * LOOP_V_STEP_MV;
	endproperty
	a_loop_v_scale: assert property (p_loop_v_scale) else $error("loop voltage code off its 1.5 V scale");

	property p_loop_i_scale;
		@(posedge core_clk) disable iff (sys_rst)
		meas_valid && loop_i_abs < LOOP_I_STEP_UA * 63 |=>
			CALC_W'(loop_i_r[MAG_MSB:0]) * LOOP_I_STEP_UA <= $past(loop_i_abs)
			&& $past(loop_i_abs) < (CALC_W'(loop_i_r[MAG_MSB:0]) + 1) * LOOP_I_STEP_UA;
	endproperty
	a_loop_i_scale: assert property (p_loop_i_scale) else $error("loop current code off its 1.25 mA scale");

	property p_loop_i_top;
		@(posedge core_clk) disable iff (sys_rst)
		meas_valid && loop_i_abs >= LOOP_I_STEP_UA * 64 |=> loop_i_r[MAG_MSB:0] == MAG_MAX;
	endproperty
	a_loop_i_top: assert property (p_loop_i_top) else $error("loop current not pinned at full scale");

	property p_tip_top;
		@(posedge core_clk) disable iff (sys_rst)
		meas_valid && tip_mag >= GND_V_STEP_MV * 255 |=> tip_r == CODE_MAX;
	endproperty
	a_tip_top: assert property (p_tip_top) else $error("tip code not pinned at full scale");

	property p_ring_scale;
		@(posedge core_clk) disable iff (sys_rst)
		meas_valid && ring_mag < GND_V_STEP_MV * 255 |=>
			CALC_W'(ring_r) * GND_V_STEP_MV <= $past(ring_mag) && $past(ring_mag) < (CALC_W'(ring_r) + 1) * GND_V_STEP_MV;
	endproperty
	a_ring_scale: assert property (p_ring_scale) else $error("ring code off its 0.376 V scale");

	property p_ring_top;
		@(posedge core_clk) disable iff (sys_rst)
		meas_valid && ring_mag >= GND_V_STEP_MV * 255 |=> ring_r == CODE_MAX;
	endproperty
	a_ring_top: assert property (p_ring_top) else $error("ring code not pinned at full scale");

	property p_power_q6;
		@(posedge core_clk) disable iff (sys_rst)
		meas_valid && CALC_W'(xstr_power_uw[NUM_XSTR-1]) < PWR_BIG_STEP * 255 |=>
			CALC_W'(xstr_code_r[NUM_XSTR-1]) * PWR_BIG_STEP <= CALC_W'($past(xstr_power_uw[NUM_XSTR-1]))
			&& CALC_W'($past(xstr_power_uw[NUM_XSTR-1])) < (CALC_W'(xstr_code_r[NUM_XSTR-1]) + 1) * PWR_BIG_STEP;
	endproperty
	a_power_q6: assert property (p_power_q6) else $error("Q6 power code off its 30.4 mW scale");

	property p_sel_write;
		@(posedge core_clk) disable iff (sys_rst)
		wr_sel |=> sel_r == $past(reg_wdata[SEL_W-1:0]);
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("pointer write did not land");

	// Data must not linger, or a stale value passes for a fresh read
	property p_rdata_idle;
		@(posedge core_clk) disable iff (sys_rst)
		!reg_rd |=> reg_rdata == RD_IDLE;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data stood outside its answer cycle");

	c_read_power: cover property (@(posedge core_clk) disable iff (sys_rst) wr_sel ##1 reg_rd && hit_pwr);
	c_reverse_loop: cover property (@(posedge core_clk) disable iff (sys_rst) meas_valid && loop_diff < 0);
	c_tip_full: cover property (@(posedge core_clk) disable iff (sys_rst) meas_valid ##1 tip_r == CODE_MAX);
	c_back_to_back: cover property (@(posedge core_clk) disable iff (sys_rst) reg_rd ##1 reg_rd);
	c_undefined_read: cover property (@(posedge core_clk) disable iff (sys_rst) reg_rd && hit_pwr && !sel_defined);

endmodule : line_monitor_readback

// *** test/line_sense_source.sv ***
// Converter stand-in: presents one sample set per call with a one-cycle strobe.
// Assumes callers enter apply() just after a rising core_clk edge.
`timescale 1ns/100ps
module line_sense_source
	import line_monitor_pkg::*;
(
	input wire logic core_clk, // Sample clock
	output logic meas_valid, // Sample strobe
	output logic [NUM_XSTR-1:0][23:0] xstr_power_uw, // Power per transistor, uW
	output logic signed [17:0] tip_mv, // Tip to ground, mV
	output logic signed [17:0] ring_mv, // Ring to ground, mV
	output logic signed [17:0] loop_ua // Loop current, uA
);
	initial
	begin
		meas_valid = 1'b0;
		xstr_power_uw = '0;
		tip_mv = '0;
		ring_mv = '0;
		loop_ua = '0;
	end

	task automatic apply(input logic [NUM_XSTR-1:0][23:0] p, input int t, input int r, input int c);
		meas_valid <= 1'b1;
		xstr_power_uw <= p;
		tip_mv <= t[17:0];
		ring_mv <= r[17:0];
		loop_ua <= c[17:0];
		@(posedge core_clk);
		meas_valid <= 1'b0;
		// Stale after the strobe; inverted so a late capture shows up
		xstr_power_uw <= ~p;
		tip_mv <= ~t[17:0];
		ring_mv <= ~r[17:0];
		loop_ua <= ~c[17:0];
	endtask : apply
endmodule : line_sense_source

// *** test/test_line_monitor_readback.sv ***
// Self-checking bench for the line monitor readback registers.
// Assumes line_sense_source as converter and the package register map.
`timescale 1ns/100ps
module test_line_monitor_readback;
	import line_monitor_pkg::*;
`define CHK(g, e) begin checked++; if ((g) !== (e)) bad(8'(g), 8'(e)); end
	logic core_clk, sys_rst, reg_wr, reg_rd, meas_valid;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, a;
	logic [2:0] power_monitor_select, s;
	logic [NUM_XSTR-1:0][23:0] xstr_power_uw, p;
	logic signed [17:0] tip_mv, ring_mv, loop_ua;
	logic [7:0] ex[5];
	int checked, mismatches;
	// Mixed polarities, saturation, exact steps and a zero set
	int tv[5] = '{-752, -95880, 5000, -10000, 0};
	int rv[5] = '{-100000, -40000, -375, -8501, 0};
	int cv[5] = '{30000, -30000, 78750, -100000, 0};

	line_monitor_readback i_line_monitor_readback (.core_clk(core_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.meas_valid(meas_valid), .xstr_power_uw(xstr_power_uw), .tip_mv(tip_mv), .ring_mv(ring_mv),
		.loop_ua(loop_ua), .power_monitor_select(power_monitor_select));
	line_sense_source i_line_sense_source (.core_clk(core_clk), .meas_valid(meas_valid),
		.xstr_power_uw(xstr_power_uw), .tip_mv(tip_mv), .ring_mv(ring_mv), .loop_ua(loop_ua));

	function automatic logic [7:0] code(input int v, input int st, input int top);
		int q;
		q = (v < 0) ? 0 : v / st;
		return (q > top) ? top[7:0] : q[7:0];
	endfunction : code

	function automatic int step(input int x);
		return (x == 2 || x == 3) ? 3620 : 30400;
	endfunction : step

	task automatic bad(input logic [7:0] g, input logic [7:0] e);
		mismatches++;
		$display("unexpected at %0t got %h expected %h", $time, g, e);
	endtask : bad

	task automatic stop_test();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	// Leaves strobe low at exit, so a following rd can start at once
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] ad, input logic [7:0] e);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		`CHK(reg_rdata, e)
		@(posedge core_clk);
	endtask : rd

	task automatic pair(input logic [7:0] e_tip, input logic [7:0] e_ring);
		reg_rd <= 1'b1;
		reg_addr <= ADDR_TIP;
		@(posedge core_clk);
		reg_addr <= ADDR_RING;
		@(negedge core_clk);
		`CHK(reg_rdata, e_tip)
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		`CHK(reg_rdata, e_ring)
		@(negedge core_clk);
		`CHK(reg_rdata, 8'h00)
		@(posedge core_clk);
	endtask : pair

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	initial
	begin
		#50000;
		mismatches++;
		stop_test();
	end

	initial
	begin
		sys_rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		checked = 0;
		mismatches = 0;
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		for (a = ADDR_PWR_SEL; a <= ADDR_RING; a++)
			rd(a, 8'h00);
		for (int i = 0; i < 5; i++)
		begin
			for (int x = 0; x < NUM_XSTR; x++)
				p[x] = (i == 4) ? 24'h7704C0 : 24'(step(x) * (40 * x + 5 * i + 1) - 1);
			i_line_sense_source.apply(p, tv[i], rv[i], cv[i]);
			ex[0] = 8'h00;
			ex[1] = (tv[i] < rv[i] ? 8'h40 : 8'h00) | code(tv[i] < rv[i] ? rv[i] - tv[i] : tv[i] - rv[i], 1500, 63);
			ex[2] = (cv[i] < 0 ? 8'h40 : 8'h00) | code(cv[i] < 0 ? -cv[i] : cv[i], 1250, 63);
			ex[3] = code(-tv[i], 376, 255);
			ex[4] = code(-rv[i], 376, 255);
			pair(ex[3], ex[4]);
			rd(ADDR_LOOP_V, ex[1]);
			rd(ADDR_LOOP_I, ex[2]);
			for (int k = 0; k < 8; k++)
			begin
				s = k[2:0];
				wr(ADDR_PWR_SEL, {5'h1F, s});
				rd(ADDR_PWR, k > 5 ? 8'h00 : code(int'(p[k]), step(k), 255));
				`CHK(power_monitor_select, s)
			end
		end
		rd(ADDR_PWR_SEL, 8'h07);
		for (int j = 0; j < 5; j++)
		begin
			wr(ADDR_PWR + 8'(j), 8'hA5);
			rd(ADDR_PWR + 8'(j), ex[j]);
		end
		wr(8'h60, 8'hA5);
		rd(8'h60, 8'h00);
		rd(ADDR_PWR_SEL, 8'h07);
		// Reset in mid-run: captured codes and the pointer must clear
		i_line_sense_source.apply(p, tv[1], rv[1], cv[1]);
		rd(ADDR_TIP, code(-tv[1], 376, 255));
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		`CHK(power_monitor_select, 3'h0)
		for (a = ADDR_PWR_SEL; a <= ADDR_RING; a++)
			rd(a, 8'h00);
		stop_test();
	end
endmodule : test_line_monitor_readback
